// ===== ees_slave.sv
// two-wire serial eeprom slave front end with page buffer and write timer
`default_nettype none

// Operation
// - both lines high with no transfer means bus idle.
// - data falling while clock high is start; device detects it.
// - data rising while clock high is stop; device detects it.
// - every byte moves most significant bit first.
// - data changes only with clock low; one bit per clock pulse.
// - transmitter releases data after a byte; receiver pulls low on ninth clock.
// - no acknowledge at all while the internal write cycle runs.
// - in reads, sample ninth clock; on acknowledge send the next byte.
// - without master acknowledge, release data and wait for stop.
// - upper four address bits must match the device type identifier.
// - next three address bits must match the device select straps.
// - eighth address bit one means read, zero means write.
// - write protect high blocks programming; low permits it.
// - device select inputs are the device's own address bits.
// - page write buffers up to 64 bytes, programmed in one cycle.
// - hold driven data at least 300 ns after clock falls.
// - write is address, high then low word address, data; stop programs.
// - pointer advances per data byte and wraps inside the page.
// - with write protect, still acknowledge all, but start no write.
// - pointer holds last address plus one; reads walk and wrap the array.
module ees_slave
	import ees_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_W,
	parameter int PAGE_BITS = PAGE_W,
	parameter int WRITE_CYC = WR_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic i_write_protect,
	input wire logic i_device_select_bit0,
	input wire logic i_device_select_bit1,
	input wire logic i_device_select_bit2,
	input wire logic [BYTE_W-1:0] i_mem_rdata,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	output logic [ADDR_BITS-1:0] o_mem_addr,
	output logic [BYTE_W-1:0] o_mem_wdata,
	output logic o_mem_we,
	output logic o_busy
);

	localparam int PAGE_N = 1 << PAGE_BITS;
	localparam int HI_BITS = ADDR_BITS - BYTE_W;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and edge detection

	logic [PIN_N-1:0] pin_s1_q;
	logic [PIN_N-1:0] pin_s2_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [2:0] dev_sel;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
		end else begin
			pin_s1_q <= {i_device_select_bit2, i_device_select_bit1,
				i_device_select_bit0, i_write_protect, i_sda_in, i_scl};
			pin_s2_q <= pin_s1_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= pin_s2_q[PIN_SCL];
			sda_prev_q <= pin_s2_q[PIN_SDA];
		end
	end

	assign scl_rise = pin_s2_q[PIN_SCL] && !scl_prev_q;
	assign scl_fall = !pin_s2_q[PIN_SCL] && scl_prev_q;
	assign start_det = pin_s2_q[PIN_SCL] && scl_prev_q &&
		!pin_s2_q[PIN_SDA] && sda_prev_q;
	assign stop_det = pin_s2_q[PIN_SCL] && scl_prev_q &&
		pin_s2_q[PIN_SDA] && !sda_prev_q;
	assign dev_sel = {pin_s2_q[PIN_DS2], pin_s2_q[PIN_DS1],
		pin_s2_q[PIN_DS0]};

	////////////////////////////////////////////////////////////////////////
	// bus protocol state

	ees_bus_st_t st_q;
	ees_prog_st_t pst_q;
	logic [3:0] bit_cnt_q;
	logic [1:0] byte_idx_q;
	logic [BYTE_W-1:0] shift_q;
	logic read_q;
	logic master_ack_q;
	logic [ADDR_BITS-1:0] ptr_q;
	logic wr_pend_q;
	logic drv_next_q;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic [BYTE_W-1:0] page_q [PAGE_N];
	logic [PAGE_N-1:0] page_vld_q;
	logic [PAGE_BITS-1:0] flush_idx_q;
	logic [31:0] wr_cnt_q;
	logic busy;
	logic addr_match;

	assign busy = (pst_q != PG_IDLE);
	assign addr_match = (shift_q[7:4] == DEV_TYPE_ID) &&
		(shift_q[3:1] == dev_sel);

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_q <= ST_IDLE;
			bit_cnt_q <= BIT_ZERO;
			byte_idx_q <= IDX_DEV;
			shift_q <= '0;
			read_q <= 1'b0;
			master_ack_q <= 1'b0;
		end else if (start_det) begin
			st_q <= ST_RX;
			bit_cnt_q <= BIT_ZERO;
			byte_idx_q <= IDX_DEV;
		end else if (stop_det) begin
			st_q <= ST_IDLE;
		end else begin
			unique case (st_q)
			ST_IDLE, ST_WAIT: begin
			end
			ST_RX: begin
				if (scl_rise) begin
					shift_q <= {shift_q[BYTE_W-2:0], pin_s2_q[PIN_SDA]};
					bit_cnt_q <= bit_cnt_q + BIT_ONE;
				end else if (scl_fall && bit_cnt_q == BIT_LAST) begin
					if (byte_idx_q == IDX_DEV) begin
						read_q <= shift_q[0];
						st_q <= (addr_match && !busy) ? ST_RX_ACK : ST_WAIT;
					end else begin
						st_q <= ST_RX_ACK;
					end
				end
			end
			ST_RX_ACK: begin
				if (scl_fall) begin
					bit_cnt_q <= BIT_ZERO;
					if (byte_idx_q != IDX_DATA) begin
						byte_idx_q <= byte_idx_q + 2'h1;
					end
					if (byte_idx_q == IDX_DEV && read_q) begin
						shift_q <= i_mem_rdata;
						st_q <= ST_TX;
					end else begin
						st_q <= ST_RX;
					end
				end
			end
			ST_TX: begin
				if (scl_rise) begin
					bit_cnt_q <= bit_cnt_q + BIT_ONE;
				end else if (scl_fall) begin
					if (bit_cnt_q == BIT_LAST) begin
						st_q <= ST_TX_ACK;
					end else begin
						shift_q <= {shift_q[BYTE_W-2:0], 1'b0};
					end
				end
			end
			ST_TX_ACK: begin
				if (scl_rise) begin
					master_ack_q <= !pin_s2_q[PIN_SDA];
				end else if (scl_fall) begin
					bit_cnt_q <= BIT_ZERO;
					if (master_ack_q) begin
						shift_q <= i_mem_rdata;
						st_q <= ST_TX;
					end else begin
						st_q <= ST_WAIT;
					end
				end
			end
			default: begin
				st_q <= ST_IDLE;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// word pointer and page buffer

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			ptr_q <= '0;
		end else if (st_q == ST_RX && scl_fall && bit_cnt_q == BIT_LAST) begin
			unique case (byte_idx_q)
			IDX_HI: ptr_q[ADDR_BITS-1:BYTE_W] <= shift_q[HI_BITS-1:0];
			IDX_LO: ptr_q[BYTE_W-1:0] <= shift_q;
			IDX_DATA: ptr_q[PAGE_BITS-1:0] <= ptr_q[PAGE_BITS-1:0] +
				{{(PAGE_BITS-1){1'b0}}, 1'b1};
			default: begin
			end
			endcase
		end else if (st_q == ST_TX && scl_fall && bit_cnt_q == BIT_LAST) begin
			ptr_q <= ptr_q + {{(ADDR_BITS-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (st_q == ST_RX && scl_fall && bit_cnt_q == BIT_LAST &&
			byte_idx_q == IDX_DATA) begin
			page_q[ptr_q[PAGE_BITS-1:0]] <= shift_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			page_vld_q <= '0;
			wr_pend_q <= 1'b0;
		end else if (start_det && st_q == ST_IDLE) begin
			page_vld_q <= '0;
			wr_pend_q <= 1'b0;
		end else if (st_q == ST_RX && scl_fall && bit_cnt_q == BIT_LAST &&
			byte_idx_q == IDX_DATA) begin
			page_vld_q[ptr_q[PAGE_BITS-1:0]] <= 1'b1;
			wr_pend_q <= 1'b1;
		end else if (stop_det) begin
			wr_pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal write cycle: flush buffered bytes, then time the programming

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pst_q <= PG_IDLE;
			flush_idx_q <= '0;
			wr_cnt_q <= '0;
		end else begin
			unique case (pst_q)
			PG_IDLE: begin
				if (stop_det && wr_pend_q && !pin_s2_q[PIN_WP]) begin
					pst_q <= PG_FLUSH;
					flush_idx_q <= '0;
				end
			end
			PG_FLUSH: begin
				flush_idx_q <= flush_idx_q + {{(PAGE_BITS-1){1'b0}}, 1'b1};
				if (flush_idx_q == {PAGE_BITS{1'b1}}) begin
					pst_q <= PG_WAIT;
					wr_cnt_q <= '0;
				end
			end
			PG_WAIT: begin
				wr_cnt_q <= wr_cnt_q + 32'h0000_0001;
				if (wr_cnt_q == 32'(WRITE_CYC - 1)) begin
					pst_q <= PG_IDLE;
				end
			end
			default: begin
				pst_q <= PG_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_mem_addr <= '0;
			o_mem_wdata <= '0;
			o_mem_we <= 1'b0;
			o_busy <= 1'b0;
		end else begin
			o_busy <= busy;
			if (pst_q == PG_FLUSH) begin
				o_mem_addr <= {ptr_q[ADDR_BITS-1:PAGE_BITS], flush_idx_q};
				o_mem_wdata <= page_q[flush_idx_q];
				o_mem_we <= page_vld_q[flush_idx_q];
			end else begin
				o_mem_addr <= ptr_q;
				o_mem_we <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// open-drain data output with hold delay after clock fall

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			drv_next_q <= 1'b0;
			hold_cnt_q <= '0;
			o_sda_oe_n <= 1'b1;
			o_sda_out <= 1'b0;
		end else if (start_det || stop_det) begin
			drv_next_q <= 1'b0;
			hold_cnt_q <= '0;
			o_sda_oe_n <= 1'b1;
		end else if (scl_fall) begin
			hold_cnt_q <= HOLD_W'(HOLD_CYC);
			unique case (st_q)
			ST_RX: drv_next_q <= (bit_cnt_q == BIT_LAST) &&
				(byte_idx_q != IDX_DEV || (addr_match && !busy));
			ST_RX_ACK: drv_next_q <= (byte_idx_q == IDX_DEV) && read_q &&
				!i_mem_rdata[BYTE_W-1];
			ST_TX: drv_next_q <= (bit_cnt_q != BIT_LAST) &&
				!shift_q[BYTE_W-2];
			ST_TX_ACK: drv_next_q <= master_ack_q &&
				!i_mem_rdata[BYTE_W-1];
			default: drv_next_q <= 1'b0;
			endcase
		end else if (hold_cnt_q != '0) begin
			hold_cnt_q <= hold_cnt_q - HOLD_W'(1);
			if (hold_cnt_q == HOLD_W'(1)) begin
				o_sda_oe_n <= !drv_next_q;
			end
		end
	end

endmodule

`default_nettype wire

// ===== ees_pkg.sv
// shared constants and types of the serial eeprom slave front end
`default_nettype none

package ees_pkg;

	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int HOLD_NS = 300;
	localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_TIME_NS = 5_000_000;
	localparam int WR_CYC = WR_TIME_NS / CLK_PERIOD_NS;
	localparam int HOLD_W = 7;

	// geometry
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 6;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;

	// device type identifier, value arbitrary
	localparam logic [3:0] DEV_TYPE_ID = 4'h5;

	// synchronised pin vector positions
	localparam int PIN_N = 6;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_DS0 = 3;
	localparam int PIN_DS1 = 4;
	localparam int PIN_DS2 = 5;

	// byte position within a transfer
	localparam logic [1:0] IDX_DEV = 2'h0;
	localparam logic [1:0] IDX_HI = 2'h1;
	localparam logic [1:0] IDX_LO = 2'h2;
	localparam logic [1:0] IDX_DATA = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_RX_ACK = 3'b010,
		ST_TX = 3'b011,
		ST_TX_ACK = 3'b100,
		ST_WAIT = 3'b101
	} ees_bus_st_t;

	typedef enum logic [1:0] {
		PG_IDLE = 2'b00,
		PG_FLUSH = 2'b01,
		PG_WAIT = 2'b10
	} ees_prog_st_t;

endpackage

`default_nettype wire

// ===== ees_slave_sva.sv
// assertion checker for the eeprom slave front end
`default_nettype none
module ees_slave_chk
	import ees_pkg::*;
#(
	parameter int ADDR_BITS = ADDR_W,
	parameter int PAGE_BITS = PAGE_W,
	parameter int WRITE_CYC = WR_CYC
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_scl,
	input wire logic i_sda_in,
	input wire logic i_write_protect,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic [ADDR_BITS-1:0] o_mem_addr,
	input wire logic o_mem_we,
	input wire logic o_busy
);
	logic [7:0] low_q;
	logic [31:0] busy_q;
	logic [ADDR_BITS-1:0] addr_q;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	////////////////////////
	always_ff @(posedge i_clk_sys) begin
		low_q <= (i_reset || i_scl) ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
	end
	always_ff @(posedge i_clk_sys) begin
		busy_q <= o_busy ? busy_q + 32'h0000_0001 : 32'h0000_0000;
		addr_q <= o_mem_addr;
	end
	sequence s_start;
		i_scl && $fell(i_sda_in);
	endsequence
	sequence s_stop;
		i_scl && $rose(i_sda_in);
	endsequence
	property p_rst;
		disable iff (1'b0) i_reset [*3] |-> o_sda_oe_n && !o_mem_we && !o_busy;
	endproperty
	property p_start;
		s_start |-> ##[1:8] o_sda_oe_n;
	endproperty
	property p_stop;
		s_stop |-> ##[1:8] o_sda_oe_n;
	endproperty
	property p_hold;
		$changed(o_sda_oe_n) && !i_scl |-> low_q >= 8'(HOLD_CYC);
	endproperty
	property p_busy;
		o_busy |-> o_sda_oe_n;
	endproperty
	property p_wp;
		i_write_protect [*8] |-> !$rose(o_busy);
	endproperty
	property p_cyc;
		$fell(o_busy) |-> busy_q >= WRITE_CYC && busy_q <= WRITE_CYC + 70;
	endproperty
	property p_page;
		o_mem_we && $past(o_mem_we) |->
			(o_mem_addr >> PAGE_BITS) == (addr_q >> PAGE_BITS);
	endproperty
	property p_od;
		!o_sda_out;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	a_start: assert property (p_start) else $error("start");
	a_stop: assert property (p_stop) else $error("stop");
	a_hold: assert property (p_hold) else $error("hold");
	a_busy: assert property (p_busy) else $error("busy ack");
	a_wp: assert property (p_wp) else $error("protect");
	a_cyc: assert property (p_cyc) else $error("cycle");
	a_page: assert property (p_page) else $error("page");
	a_od: assert property (p_od) else $error("drain");
endmodule
bind ees_slave ees_slave_chk #(.ADDR_BITS(ADDR_BITS),
	.PAGE_BITS(PAGE_BITS), .WRITE_CYC(WRITE_CYC)) u_chk (
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_scl(i_scl),
	.i_sda_in(i_sda_in), .i_write_protect(i_write_protect),
	.o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
	.o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_busy(o_busy));
`default_nettype wire

// ===== ees_master.sv
// behavioural two-wire bus master
`default_nettype none
module ees_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	////////////////////////
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic start();
		// clock stays low past the slave's hold before it rises
		wt(25);
		o_sda = 1'b1;
		wt(75);
		o_scl = 1'b1;
		wt(50);
		o_sda = 1'b0;
		wt(50);
		o_scl = 1'b0;
	endtask
	task automatic stop();
		wt(25);
		o_sda = 1'b0;
		wt(75);
		o_scl = 1'b1;
		wt(50);
		o_sda = 1'b1;
		wt(100);
	endtask
	task automatic bit_io(input logic b, output logic r);
		wt(25);
		o_sda = b;
		wt(75);
		o_scl = 1'b1;
		wt(50);
		r = i_sda;
		wt(50);
		o_scl = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a,
		output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(a, k);
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the eeprom slave front end
`default_nettype none
module tb_top
	import ees_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WCYC = 4000;
	logic i_clk_sys = 1'b0, i_reset = 1'b1, wp = 1'b0;
	logic [2:0] sel = 3'h0;
	logic scl, msda, sda, sout, oen, we, busy, ak;
	logic [14:0] addr, a;
	logic [7:0] wdat, rdat, q, d [3];
	logic [22:0] e;
	logic [22:0] exp_q [$];
	int num_errors = 0, comparisons = 0;
	function automatic logic [7:0] mf(input logic [14:0] x);
		return x[7:0] ^ {1'b0, x[14:8]};
	endfunction
	assign rdat = mf(addr);
	assign sda = msda & (oen | sout);
	ees_slave #(.WRITE_CYC(WCYC)) u_dut (
		.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_scl(scl),
		.i_sda_in(sda), .i_write_protect(wp),
		.i_device_select_bit0(sel[0]), .i_device_select_bit1(sel[1]),
		.i_device_select_bit2(sel[2]), .i_mem_rdata(rdat),
		.o_sda_out(sout), .o_sda_oe_n(oen), .o_mem_addr(addr),
		.o_mem_wdata(wdat), .o_mem_we(we), .o_busy(busy));
	ees_master u_mst (.i_clk(i_clk_sys), .i_sda(sda), .o_scl(scl),
		.o_sda(msda));
	////////////////////////
	task automatic check(input string n, input logic [22:0] s, x);
		comparisons++;
		if (s !== x) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, x, s);
		end
	endtask
	task automatic conclude();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wb(input logic [7:0] v, input logic k);
		u_mst.xfer(v, 1'b1, q, ak);
		check("ack", 23'(ak), 23'(k));
	endtask
	task automatic rb(input logic n, input logic [14:0] x);
		u_mst.xfer(8'hff, n, q, ak);
		check("read", 23'(q), 23'(mf(x)));
	endtask
	task automatic dev(input logic [2:0] s, input logic r, input logic k);
		u_mst.start();
		wb({DEV_TYPE_ID, s, r}, k);
	endtask
	initial begin
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	always @(negedge i_clk_sys) begin
		if (we === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
			check("write", {addr, wdat}, e);
		end
	end
	initial begin
		#400_000;
		num_errors++;
		conclude();
	end
	initial begin
		sel = 3'($urandom(77));
		a = {9'($urandom()), 6'h3e};
		repeat (3) @(posedge i_clk_sys);
		#1 i_reset = 1'b0;
		u_mst.wt(5);
		check("idle", 23'({oen, busy}), 23'h2);
		dev(sel, 1'b0, 1'b0);
		wb({1'b0, a[14:8]}, 1'b0);
		wb(a[7:0], 1'b0);
		for (int i = 0; i < 3; i++) begin
			d[i] = 8'($urandom());
			wb(d[i], 1'b0);
		end
		exp_q = '{{a[14:6], 6'h00, d[2]}, {a, d[0]}, {a + 15'h1, d[1]}};
		u_mst.stop();
		dev(sel, 1'b1, 1'b1);
		u_mst.stop();
		for (int i = 0; i < 5000 && busy !== 1'b0; i++) begin
			u_mst.wt(1);
		end
		dev(sel, 1'b1, 1'b0);
		rb(1'b1, {a[14:6], 6'h01});
		u_mst.stop();
		u_mst.start();
		wb({~DEV_TYPE_ID, sel, 1'b0}, 1'b1);
		u_mst.stop();
		dev(sel ^ 3'h5, 1'b0, 1'b1);
		u_mst.stop();
		dev(sel, 1'b0, 1'b0);
		wb(8'h7f, 1'b0);
		wb(8'hff, 1'b0);
		dev(sel, 1'b1, 1'b0);
		rb(1'b0, 15'h7fff);
		rb(1'b1, 15'h0000);
		u_mst.wt(100);
		check("release", 23'(oen), 23'h1);
		u_mst.stop();
		wp = 1'b1;
		dev(sel, 1'b0, 1'b0);
		wb(8'h01, 1'b0);
		wb(8'h00, 1'b0);
		wb(8'($urandom()), 1'b0);
		u_mst.stop();
		u_mst.wt(300);
		check("protect", 23'(busy), 23'h0);
		wp = 1'b0;
		check("pending", 23'(exp_q.size()), 23'h0);
		conclude();
	end
endmodule
`default_nettype wire
